// ---- common/erase_seq_map.vh ----
// Constants for the serial flash erase sequencer: opcodes, status layout,
// frame lengths and erase timing.
// Assumes a 100 MHz system clock; included by the core files by bare name.
`ifndef ERASE_SEQ_MAP_VH
`define ERASE_SEQ_MAP_VH

// Instruction codes
`define OP_SECTOR_ERASE   8'h20
`define OP_BLOCK32_ERASE  8'h52
`define OP_BLOCK64_ERASE  8'hd8
`define OP_CHIP_ERASE_A   8'hc7
`define OP_CHIP_ERASE_B   8'h60
`define OP_WRITE_ENABLE   8'h06
`define OP_WRITE_DISABLE  8'h04
`define OP_READ_STATUS    8'h05

// Frame lengths in serial bits
`define BITS_OPCODE       6'h08
`define BITS_ADDR_CMD     6'h20
`define BITS_MAX          6'h3f
`define BIT_OPCODE_LAST   6'h07

// Status byte layout
`define STAT_WIP          0
`define STAT_WEL          1
`define STAT_BP_LO        2
`define STAT_BP_HI        4

// Reset values
`define WEL_RESET         1'b0
`define WIP_RESET         1'b0

// Erase kinds
`define KIND_SECTOR       2'h0
`define KIND_BLOCK32      2'h1
`define KIND_BLOCK64      2'h2
`define KIND_CHIP         2'h3

// Address masks (1 MB array, 24-bit address)
`define MASK_SECTOR       24'h0ff000
`define MASK_BLOCK32      24'h0f8000
`define MASK_BLOCK64      24'h0f0000
`define ADDR_ZERO         24'h000000
`define BLOCK_IDX_HI      19
`define BLOCK_IDX_LO      16
`define BLOCK_COUNT       5'h10

// Erased byte value
`define ERASED_BYTE       8'hff

// Erase durations, typical figures
`define CLK_MHZ                   100
`define SECTOR_ERASE_DURATION_US  100000
`define BLOCK32_ERASE_DURATION_US 300000
`define BLOCK64_ERASE_DURATION_US 500000
`define CHIP_ERASE_DURATION_US    8000000

`endif

// ---- core/spi_pin_sync.v ----
// Pin synchroniser for the serial flash port: two synchronising flops per pin, plus a
// third flop per pin for edge detection on the synchronised copies.
// Assumes chip select, serial clock and serial input are asynchronous pins.
`timescale 1ns/1ps
`include "erase_seq_map.vh"

module spi_pin_sync
(
    // Clock and control
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire       ce,
    // Pins: {cs_n, sclk, si}
    input  wire [2:0] pins_in,
    // Synchronised view
    output wire       cs_low,
    output wire       si_bit,
    output wire       sclk_rise,
    output wire       sclk_fall,
    output wire       cs_rise,
    output wire       cs_fall
);

    wire [2:0] sync_q;
    wire [2:0] prev_q;

    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1)
        begin : g_sync
            reg s1_q;
            reg s2_q;
            reg s3_q;
            always @(posedge clk_sys)
            begin
                if (!rst_n)
                begin
                    // Idle pin levels: cs high, sclk low, si low
                    s1_q <= (i == 2) ? 1'b1 : 1'b0;
                    s2_q <= (i == 2) ? 1'b1 : 1'b0;
                    s3_q <= (i == 2) ? 1'b1 : 1'b0;
                end
                else if (ce)
                begin
                    s1_q <= pins_in[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                end
            end
            assign sync_q[i] = s2_q;
            assign prev_q[i] = s3_q;
        end
    endgenerate

    // Edges are only seen on the second and third stages
    assign cs_low    = ~sync_q[2];
    assign si_bit    = sync_q[0];
    assign sclk_rise = sync_q[1] & ~prev_q[1];
    assign sclk_fall = ~sync_q[1] & prev_q[1];
    assign cs_rise   = sync_q[2] & ~prev_q[2];
    assign cs_fall   = ~sync_q[2] & prev_q[2];

endmodule // spi_pin_sync

// ---- core/spi_flash_erase_sequencer.v ----
// Erase command logic of a serial NOR flash: frame decode, write-enable
// latch, block protection, self-timed erase cycle and status read-out.
// Assumes the host drives cs_n, sclk and si as asynchronous pins, sclk much
// slower than clk_sys, and that the array outside acts on erase_start_q.
//
// Notes on behaviour
// - 20h plus three address bytes erases the whole 4 KB sector addressed.
// - 52h plus three address bytes erases the whole 32 KB block addressed.
// - D8h plus three address bytes erases the whole 64 KB block addressed.
// - C7h or 60h alone, decoded identically, selects chip erase.
// - Chip erase leaves every byte at FFh.
// - Erase accepted only with write-enable latch already set.
// - Address erase runs only if chip select rises right after bit 32.
// - Chip erase runs only if chip select rises right after bit 8.
// - Valid chip select rise starts the self-timed erase cycle.
// - Write-in-progress reads 1 through the cycle, 0 when done.
// - Status reads still answered during an erase cycle.
// - Sector and block erase clear write-enable latch before cycle ends.
// - Write-enable latch reads 0 after chip erase finishes.
// - Sector erase inside a protected area is rejected.
// - Block erase inside a protected area is rejected.
// - Chip erase refused whenever any block is protected.
// - After chip erase ends, instructions are accepted again.
`timescale 1ns/1ps
`include "erase_seq_map.vh"

module spi_flash_erase_sequencer
#(
    parameter [31:0] SECTOR_ERASE_CYC  = `SECTOR_ERASE_DURATION_US * `CLK_MHZ,
    parameter [31:0] BLOCK32_ERASE_CYC = `BLOCK32_ERASE_DURATION_US * `CLK_MHZ,
    parameter [31:0] BLOCK64_ERASE_CYC = `BLOCK64_ERASE_DURATION_US * `CLK_MHZ,
    parameter [31:0] CHIP_ERASE_CYC    = `CHIP_ERASE_DURATION_US * `CLK_MHZ
)
(
    // Clock, reset, enable
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire        ce,
    // Serial flash pins
    input  wire        cs_n,
    input  wire        sclk,
    input  wire        si,
    output reg         so_q,
    output reg         so_oe_q,
    // Block protect level
    input  wire        protect_level_bit2,
    input  wire        protect_level_bit1,
    input  wire        protect_level_bit0,
    // Status
    output reg         write_enable_latch_q,
    output reg         write_in_progress_q,
    // Erase request to the array
    output reg         erase_start_q,
    output reg  [1:0]  erase_kind_q,
    output reg  [23:0] erase_base_q,
    output reg  [7:0]  erase_fill_q,
    output reg         erase_done_q,
    output reg         cmd_reject_q
);

    // Erase cycle states
    localparam [0:0] ST_IDLE = 1'b0;
    localparam [0:0] ST_BUSY = 1'b1;

    wire        cs_low;
    wire        si_bit;
    wire        sclk_rise;
    wire        sclk_fall;
    wire        cs_rise;
    wire        cs_fall;

    reg  [0:0]  state_q;
    reg  [0:0]  state_d;
    reg  [5:0]  bit_cnt_q;
    reg  [31:0] shift_q;
    reg  [7:0]  op_q;
    reg  [2:0]  rd_idx_q;
    reg  [31:0] timer_q;
    reg  [31:0] timer_d;

    reg         start_d;
    reg  [1:0]  kind_d;
    reg  [23:0] base_d;
    reg         reject_d;
    reg         wel_d;

    wire [2:0]  bp;
    wire [7:0]  status_byte;
    wire [7:0]  frame_op;
    wire [23:0] frame_addr;
    wire [3:0]  frame_block;
    wire        blk_protected;
    wire        any_protected;
    wire        wel_ok;

    spi_pin_sync u_sync
    (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .ce        (ce),
        .pins_in   ({cs_n, sclk, si}),
        .cs_low    (cs_low),
        .si_bit    (si_bit),
        .sclk_rise (sclk_rise),
        .sclk_fall (sclk_fall),
        .cs_rise   (cs_rise),
        .cs_fall   (cs_fall)
    );

    assign bp = {protect_level_bit2, protect_level_bit1, protect_level_bit0};

    // Live status: a poll during the cycle sees the running state
    assign status_byte = {3'h0, bp, write_enable_latch_q, write_in_progress_q};

    // Address frame: opcode in the top byte, address below
    assign frame_op    = shift_q[31:24];
    assign frame_addr  = shift_q[23:0];
    assign frame_block = frame_addr[`BLOCK_IDX_HI:`BLOCK_IDX_LO];
    assign wel_ok      = write_enable_latch_q;

    // Top-down protection: level n covers the top 2^(n-1) 64 KB blocks,
    // level 5 and above cover the whole array
    function prot_hit;
        input [2:0] lvl;
        input [3:0] blk;
        reg   [4:0] first;
        begin
            first = 5'h00;
            case (lvl)
                3'h0: first = `BLOCK_COUNT;
                3'h1: first = 5'h0f;
                3'h2: first = 5'h0e;
                3'h3: first = 5'h0c;
                3'h4: first = 5'h08;
                default: first = 5'h00;
            endcase
            prot_hit = ({1'b0, blk} >= first);
        end
    endfunction

    assign blk_protected = prot_hit(bp, frame_block);
    assign any_protected = (bp != 3'h0);

    // Serial frame capture
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            bit_cnt_q <= 6'h00;
            shift_q   <= 32'h00000000;
            op_q      <= 8'h00;
        end
        else if (ce)
        begin
            if (cs_fall)
            begin
                bit_cnt_q <= 6'h00;
                op_q      <= 8'h00;
            end
            else if (sclk_rise && cs_low)
            begin
                shift_q <= {shift_q[30:0], si_bit};
                // Saturate so an overlong frame never looks like a valid one
                if (bit_cnt_q != `BITS_MAX)
                    bit_cnt_q <= bit_cnt_q + 6'h01;
                if (bit_cnt_q == `BIT_OPCODE_LAST)
                    op_q <= {shift_q[6:0], si_bit};
            end
        end
    end

    // Status read-out, MSB first on the falling serial clock
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            so_q     <= 1'b0;
            so_oe_q  <= 1'b0;
            rd_idx_q <= 3'h0;
        end
        else if (ce)
        begin
            if (cs_fall || !cs_low)
            begin
                so_oe_q  <= 1'b0;
                rd_idx_q <= 3'h0;
            end
            else if (sclk_fall && op_q == `OP_READ_STATUS &&
                     bit_cnt_q >= `BITS_OPCODE)
            begin
                so_oe_q  <= 1'b1;
                so_q     <= status_byte[~rd_idx_q];
                rd_idx_q <= rd_idx_q + 3'h1;
            end
        end
    end

    // Command evaluation at the end of the frame
    always @*
    begin
        start_d  = 1'b0;
        kind_d   = `KIND_SECTOR;
        base_d   = `ADDR_ZERO;
        reject_d = 1'b0;
        wel_d    = write_enable_latch_q;
        if (cs_rise && state_q == ST_IDLE)
        begin
            if (bit_cnt_q == `BITS_OPCODE)
            begin
                case (shift_q[7:0])
                    `OP_WRITE_ENABLE:
                        wel_d = 1'b1;
                    `OP_WRITE_DISABLE:
                        wel_d = 1'b0;
                    `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B:
                    begin
                        if (wel_ok && !any_protected)
                        begin
                            start_d = 1'b1;
                            kind_d  = `KIND_CHIP;
                            wel_d   = 1'b0;
                        end
                        else
                            reject_d = 1'b1;
                    end
                    default:
                        reject_d = 1'b0;
                endcase
            end
            else if (bit_cnt_q == `BITS_ADDR_CMD)
            begin
                case (frame_op)
                    `OP_SECTOR_ERASE:
                    begin
                        kind_d = `KIND_SECTOR;
                        base_d = frame_addr & `MASK_SECTOR;
                    end
                    `OP_BLOCK32_ERASE:
                    begin
                        kind_d = `KIND_BLOCK32;
                        base_d = frame_addr & `MASK_BLOCK32;
                    end
                    `OP_BLOCK64_ERASE:
                    begin
                        kind_d = `KIND_BLOCK64;
                        base_d = frame_addr & `MASK_BLOCK64;
                    end
                    default:
                        kind_d = `KIND_SECTOR;
                endcase
                if (frame_op == `OP_SECTOR_ERASE || frame_op == `OP_BLOCK32_ERASE ||
                    frame_op == `OP_BLOCK64_ERASE)
                begin
                    if (wel_ok && !blk_protected)
                    begin
                        start_d = 1'b1;
                        wel_d   = 1'b0;
                    end
                    else
                        reject_d = 1'b1;
                end
            end
        end
    end

    // Erase cycle sequencing
    always @*
    begin
        state_d = state_q;
        timer_d = timer_q;
        case (state_q)
            ST_IDLE:
            begin
                if (start_d)
                begin
                    state_d = ST_BUSY;
                    case (kind_d)
                        `KIND_SECTOR:  timer_d = SECTOR_ERASE_CYC;
                        `KIND_BLOCK32: timer_d = BLOCK32_ERASE_CYC;
                        `KIND_BLOCK64: timer_d = BLOCK64_ERASE_CYC;
                        default:       timer_d = CHIP_ERASE_CYC;
                    endcase
                end
            end
            ST_BUSY:
            begin
                // Runs on clk_sys alone, no serial clock needed
                if (timer_q <= 32'h00000001)
                begin
                    state_d = ST_IDLE;
                    timer_d = 32'h00000000;
                end
                else
                    timer_d = timer_q - 32'h00000001;
            end
            default:
            begin
                state_d = ST_IDLE;
                timer_d = 32'h00000000;
            end
        endcase
    end

    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state_q              <= ST_IDLE;
            timer_q              <= 32'h00000000;
            write_enable_latch_q <= `WEL_RESET;
            write_in_progress_q  <= `WIP_RESET;
            erase_start_q        <= 1'b0;
            erase_kind_q         <= `KIND_SECTOR;
            erase_base_q         <= `ADDR_ZERO;
            erase_fill_q         <= `ERASED_BYTE;
            erase_done_q         <= 1'b0;
            cmd_reject_q         <= 1'b0;
        end
        else if (ce)
        begin
            state_q              <= state_d;
            timer_q              <= timer_d;
            write_enable_latch_q <= wel_d;
            write_in_progress_q  <= (state_d == ST_BUSY);
            erase_start_q        <= start_d;
            cmd_reject_q         <= reject_d;
            erase_done_q         <= (state_q == ST_BUSY) && (state_d == ST_IDLE);
            erase_fill_q         <= `ERASED_BYTE;
            if (start_d)
            begin
                erase_kind_q <= kind_d;
                erase_base_q <= base_d;
            end
        end
    end

endmodule // spi_flash_erase_sequencer

// ---- dv/spi_host_model.sv ----
// Host side of the serial flash link: mode 0, MSB first, chip select framing.
// Assumes the device samples si on sclk rise and drives so after sclk fall.
`timescale 1ns/1ps

module spi_host_model
(
    // Link pins
    output logic cs_n,
    output logic sclk,
    output logic si,
    input  logic so
);
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si   = 1'b0;
    end

    // Data wanders between frames so nothing leans on a stale bit
    always #40 if (cs_n) si = ~si;

    // Shifts n bits of a left-aligned word; rd keeps the last eight bits on so
    task automatic frame(input logic [39:0] word, input int n, output logic [7:0] rd);
        rd = 8'h00;
        // Off the system clock edge, so the pin never races the sampler
        #2;
        cs_n = 1'b0;
        #62.5;
        for (int i = 0; i < n; i++)
        begin
            si = word[39 - i];
            #31.25;
            sclk = 1'b1;
            rd = {rd[6:0], so};
            #62.5;
            sclk = 1'b0;
            #31.25;
        end
        cs_n = 1'b1;
        #100;
    endtask
endmodule // spi_host_model

// ---- dv/spi_flash_erase_sequencer_asserts.sv ----
// Checker for the erase sequencer's status and erase request outputs.
// Assumes erase times come in as the design's own parameters.
`timescale 1ns/1ps
`include "erase_seq_map.vh"

module spi_flash_erase_sequencer_asserts
#(
    parameter [31:0] SECTOR_ERASE_CYC  = 32'd20,
    parameter [31:0] BLOCK32_ERASE_CYC = 32'd30,
    parameter [31:0] BLOCK64_ERASE_CYC = 32'd40,
    parameter [31:0] CHIP_ERASE_CYC    = 32'd50
)
(
    // Clock and reset
    input logic        clk_sys,
    input logic        rst_n,
    // Protection level
    input logic        protect_level_bit2,
    input logic        protect_level_bit1,
    input logic        protect_level_bit0,
    // Status and erase request
    input logic        write_enable_latch_q,
    input logic        write_in_progress_q,
    input logic        erase_start_q,
    input logic [1:0]  erase_kind_q,
    input logic [23:0] erase_base_q,
    input logic [7:0]  erase_fill_q,
    input logic        erase_done_q,
    input logic        cmd_reject_q
);
    logic [31:0] busy_cnt_q;
    logic [31:0] dur;
    logic [23:0] amask;
    logic [2:0]  lvl;
    logic        blk_prot;

    assign lvl = {protect_level_bit2, protect_level_bit1, protect_level_bit0};
    // Top blocks go first; level 5 and up covers the whole array
    assign blk_prot = (lvl >= 3'h5) || ((lvl != 3'h0) && ({1'b0, erase_base_q[19:16]} >= 5'h10 - (5'h01 << (lvl - 3'h1))));
    assign dur = (erase_kind_q == `KIND_SECTOR) ? SECTOR_ERASE_CYC : (erase_kind_q == `KIND_BLOCK32) ?
                 BLOCK32_ERASE_CYC : (erase_kind_q == `KIND_BLOCK64) ? BLOCK64_ERASE_CYC : CHIP_ERASE_CYC;
    assign amask = (erase_kind_q == `KIND_SECTOR) ? 24'hf00fff : (erase_kind_q == `KIND_BLOCK32) ?
                   24'hf07fff : (erase_kind_q == `KIND_BLOCK64) ? 24'hf0ffff : 24'hffffff;

    always @(posedge clk_sys)
    begin
        if (!rst_n || !write_in_progress_q)
            busy_cnt_q <= 32'h0;
        else
            busy_cnt_q <= busy_cnt_q + 32'h1;
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    property p_start_status;
        erase_start_q |-> write_in_progress_q && !write_enable_latch_q;
    endproperty
    a_start_status: assert property (p_start_status) else $error("start without busy or latch clear");

    property p_start_wel;
        erase_start_q |-> $past(write_enable_latch_q) && !$past(write_in_progress_q);
    endproperty
    a_start_wel: assert property (p_start_wel) else $error("start without latch or while busy");

    property p_wip_len;
        $fell(write_in_progress_q) |-> busy_cnt_q == dur;
    endproperty
    a_wip_len: assert property (p_wip_len) else $error("busy length wrong");

    property p_done;
        erase_done_q == $fell(write_in_progress_q);
    endproperty
    a_done: assert property (p_done) else $error("done pulse not at busy end");

    property p_align;
        erase_start_q |-> (erase_base_q & amask) == 24'h0;
    endproperty
    a_align: assert property (p_align) else $error("erase base not aligned");

    property p_fill;
        erase_start_q |-> erase_fill_q == `ERASED_BYTE;
    endproperty
    a_fill: assert property (p_fill) else $error("fill value wrong");

    property p_chip_prot;
        erase_start_q && erase_kind_q == `KIND_CHIP |-> lvl == 3'h0;
    endproperty
    a_chip_prot: assert property (p_chip_prot) else $error("chip erase while protected");

    property p_blk_prot;
        erase_start_q && erase_kind_q != `KIND_CHIP |-> !blk_prot;
    endproperty
    a_blk_prot: assert property (p_blk_prot) else $error("protected area erased");

    property p_reject;
        cmd_reject_q |-> !erase_start_q ##1 !erase_start_q && !write_in_progress_q;
    endproperty
    a_reject: assert property (p_reject) else $error("refused erase still started");
endmodule // spi_flash_erase_sequencer_asserts

bind spi_flash_erase_sequencer spi_flash_erase_sequencer_asserts #(
    .SECTOR_ERASE_CYC(SECTOR_ERASE_CYC), .BLOCK32_ERASE_CYC(BLOCK32_ERASE_CYC),
    .BLOCK64_ERASE_CYC(BLOCK64_ERASE_CYC), .CHIP_ERASE_CYC(CHIP_ERASE_CYC)) u_asserts (
    .clk_sys(clk_sys), .rst_n(rst_n), .protect_level_bit2(protect_level_bit2),
    .protect_level_bit1(protect_level_bit1), .protect_level_bit0(protect_level_bit0),
    .write_enable_latch_q(write_enable_latch_q), .write_in_progress_q(write_in_progress_q),
    .erase_start_q(erase_start_q), .erase_kind_q(erase_kind_q), .erase_base_q(erase_base_q),
    .erase_fill_q(erase_fill_q), .erase_done_q(erase_done_q), .cmd_reject_q(cmd_reject_q));

// ---- dv/spi_flash_erase_sequencer_bench.sv ----
// Self-checking bench: host model on the link, integer reference model.
// Assumes shortened erase times so a status poll fits inside each cycle.
`timescale 1ns/1ps
`include "erase_seq_map.vh"

module spi_flash_erase_sequencer_bench;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [2:0]  lvl_q = 3'h0;
    logic        cs_n, sclk, si, so, oe, write_enable_latch, write_in_progress, start, done, rej;
    logic [1:0]  kind;
    logic [23:0] base;
    logic [7:0]  fill;
    int          failures = 0, n_compared = 0, n_start = 0, n_rej = 0, cycles = 0;
    int          n_done = 0, n_oe = 0;

    always #5 clk_sys = ~clk_sys;

    // Undriven line reads inverted, so a stale bit cannot pass for status
    spi_host_model host (.cs_n(cs_n), .sclk(sclk), .si(si), .so(oe ? so : ~so));

    spi_flash_erase_sequencer #(.SECTOR_ERASE_CYC(400), .BLOCK32_ERASE_CYC(500), .BLOCK64_ERASE_CYC(600),
        .CHIP_ERASE_CYC(700)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .cs_n(cs_n), .sclk(sclk),
        .si(si), .so_q(so), .so_oe_q(oe), .protect_level_bit2(lvl_q[2]), .protect_level_bit1(lvl_q[1]),
        .protect_level_bit0(lvl_q[0]), .write_enable_latch_q(write_enable_latch), .write_in_progress_q(write_in_progress),
        .erase_start_q(start), .erase_kind_q(kind), .erase_base_q(base), .erase_fill_q(fill),
        .erase_done_q(done), .cmd_reject_q(rej));

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    always @(posedge clk_sys)
    begin
        cycles++;
        if (start === 1'b1) n_start++;
        if (rej === 1'b1) n_rej++;
        if (done === 1'b1) n_done++;
        if (oe === 1'b1) n_oe++;
        if (cycles == 60000)
        begin
            failures++;
            test_done();
        end
    end

    function automatic bit prot(input int lvl, input int blk);
        return lvl >= 5 || (lvl != 0 && blk >= 16 - (1 << (lvl - 1)));
    endfunction

    // One write enable (or disable) frame, then one erase frame of n bits
    task automatic run(input logic [7:0] op, input logic [23:0] addr, input int n, input int lvl, input bit we);
        logic [7:0] rd;
        int s0, r0, o0, d0, k, sz, ok, go;
        s0 = n_start;
        r0 = n_rej;
        o0 = n_oe;
        d0 = n_done;
        k = (op == `OP_SECTOR_ERASE) ? 0 : (op == `OP_BLOCK32_ERASE) ? 1 : (op == `OP_BLOCK64_ERASE) ? 2 : 3;
        sz = (k == 0) ? 4096 : (k == 1) ? 32768 : (k == 2) ? 65536 : 1048576;
        ok = (k == 3) ? (n == 8) : (n == 32);
        go = ok && we && !((k == 3) ? lvl != 0 : prot(lvl, addr[19:16]));
        @(posedge clk_sys) lvl_q <= lvl[2:0];
        host.frame({we ? `OP_WRITE_ENABLE : `OP_WRITE_DISABLE, 32'h0}, 8, rd);
        chk("latch", write_enable_latch, we);
        host.frame({op, addr, 8'h00}, n, rd);
        repeat (10) @(posedge clk_sys);
        chk("starts", n_start - s0, go);
        chk("rejects", n_rej - r0, ok && !go);
        if (go)
        begin
            chk("kind", kind, k);
            chk("base", base, (addr % 1048576) / sz * sz);
            chk("fill", fill, 8'hff);
            host.frame({`OP_READ_STATUS, 32'h0}, 16, rd);
            chk("status", rd, {3'h0, lvl[2:0], 2'b01});
            chk("drive", (n_oe - o0) > 0, 1);
            chk("drive off", oe, 0);
            host.frame({`OP_WRITE_ENABLE, 32'h0}, 8, rd);
            for (int i = 0; i < 1000 && write_in_progress !== 1'b0; i++) @(posedge clk_sys);
            chk("busy end", write_in_progress, 0);
            chk("latch end", write_enable_latch, 0);
            host.frame({`OP_WRITE_ENABLE, 32'h0}, 8, rd);
            chk("latch again", write_enable_latch, 1);
            chk("done", n_done - d0, 1);
        end
    endtask

    initial
    begin
        logic [7:0] ops [0:4];
        ops = '{`OP_SECTOR_ERASE, `OP_BLOCK32_ERASE, `OP_BLOCK64_ERASE, `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B};
        void'($urandom(86));
        // Reset loads idle pin levels into the synchronisers, so two edges do
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk("reset latch", write_enable_latch, 0);
        chk("reset busy", write_in_progress, 0);
        chk("reset fill", fill, 8'hff);
        foreach (ops[i])
            run(ops[i], 24'($urandom), (i > 2) ? 8 : 32, 0, 1);
        run(`OP_SECTOR_ERASE, 24'($urandom), 32, 0, 0);
        run(`OP_SECTOR_ERASE, 24'($urandom), 31, 0, 1);
        run(`OP_BLOCK32_ERASE, 24'($urandom), 33, 0, 1);
        run(`OP_CHIP_ERASE_B, 24'h0, 9, 0, 1);
        for (int l = 1; l < 8; l++)
        begin
            run((l % 2) ? `OP_BLOCK64_ERASE : `OP_SECTOR_ERASE, 24'($urandom), 32, l, 1);
            run(`OP_CHIP_ERASE_A, 24'h0, 8, l, 1);
        end
        test_done();
    end
endmodule // spi_flash_erase_sequencer_bench
